// file: verilog/module_idle_entry_control.sv
// idle-entry power manager: idle registers, cpu gating and per-module gating
`default_nettype none
// Functional notes
// (R01) modules whose idle control bit is clear keep their clock running
// (R02) no domain idles before its outstanding transaction completes
// (R03) cpu clock stops only after the pipeline has stopped
// (R04) cpu-domain controllers and configuration registers gate after the cpu stops
// (R05) dma idles at once if idle, else after its current transfer
// (R06) idled dma wakes for serial-port transfers and returns to idle
// (R07) host port idles at once; software ensures it is inactive
// (R08) instruction cache idles after current fill or fetch, else at once
// (R09) timers, watchdog, os timer, gpio ports, clock divider idle immediately
// (R10) external-clock serial port idles after current activity, else at once
// (R11) external-clock serial port wakes for new transfer, re-idles with dma
// (R12) internal-clock serial port idles only with both resets at 0
// (R13) two-wire bus controller idles after current bus activity
// (R14) asynchronous serial port idles after current character activity
// (R15) pll and oscillator power down only if requested before idle
// (R16) external memory interface idles after current dma transfer
// (R17) idle instruction copies idle control into idle status
// (R18) peripheral gates need peripheral control bit and peripheral status bit
// (R19) dma or host gates need master control bit and master status bit
// (R20) module clock gates only after that module acknowledges idle
// (R21) a draining module accepts no new start, except the auto-wake path
module module_idle_entry_control (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // ahb-lite register bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // processor core
    input wire logic IDLE_EXEC,
    input wire logic PIPE_STOPPED,
    input wire logic CPU_WAKE,
    output logic CPU_CLK_STOP,
    output logic CPU_AUX_CLK_STOP,
    // clock generator
    output logic PLL_POWER_DOWN,
    output logic OSC_POWER_DOWN,
    // gated modules
    input wire logic [16:0] MOD_BUSY,
    input wire logic [16:0] MOD_ACK,
    output logic [16:0] MOD_IDLE_REQ,
    output logic [16:0] MOD_HOLD_START,
    output logic [16:0] MOD_CLK_STOP,
    // serial port modes
    input wire logic [1:0] SSP_EXT_CLOCK,
    input wire logic [1:0] TRANSMITTER_RESET_CTRL,
    input wire logic [1:0] RECEIVER_RESET_CTRL
);
    logic [idle_entry_pkg::ICR_W-1:0] icr_ff, nxt_icr, idle_status_reg_ff, nxt_idle_status_reg;
    logic [idle_entry_pkg::NUM_PERIPH-1:0] peripheral_idle_ctrl_ff, nxt_peripheral_idle_ctrl;
    logic [1:0] master_idle_ctrl_ff, nxt_master_idle_ctrl, pdreq_ff, nxt_pdreq;
    logic cpu_stop_ff, nxt_cpu_stop, aux_stop_ff, nxt_aux_stop;
    logic pll_pd_ff, nxt_pll_pd, osc_pd_ff, nxt_osc_pd;
    logic [idle_entry_pkg::NUM_MOD-1:0] mod_req, mod_quiet, mod_wake;
    logic wr_stb;
    logic [7:0] reg_addr;
    logic [31:0] wr_data, rd_data;

    ahb_reg_port u_bus (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .hrdata(HRDATA),
        .hreadyout(HREADYOUT),
        .hresp(HRESP),
        .wr_stb(wr_stb),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // register writes and idle status update
    always_comb begin
        nxt_icr = icr_ff;
        nxt_peripheral_idle_ctrl = peripheral_idle_ctrl_ff;
        nxt_master_idle_ctrl = master_idle_ctrl_ff;
        nxt_pdreq = pdreq_ff;
        nxt_idle_status_reg = idle_status_reg_ff;
        if (wr_stb) begin
            case (reg_addr)
                idle_entry_pkg::ADDR_IDLE_CTRL: nxt_icr = wr_data[idle_entry_pkg::ICR_W-1:0];
                idle_entry_pkg::ADDR_PERIPH_CTRL: nxt_peripheral_idle_ctrl = wr_data[idle_entry_pkg::NUM_PERIPH-1:0];
                idle_entry_pkg::ADDR_MASTER_CTRL: nxt_master_idle_ctrl = wr_data[1:0];
                idle_entry_pkg::ADDR_PWRDN_REQ: nxt_pdreq = wr_data[1:0];
                default: ;
            endcase
        end
        if (CPU_WAKE) begin
            nxt_idle_status_reg[idle_entry_pkg::ICR_CPU] = 1'b0;
            nxt_idle_status_reg[idle_entry_pkg::ICR_CLKGEN] = 1'b0;
            nxt_idle_status_reg[idle_entry_pkg::ICR_EXTERNAL_MEMORY_INTERFACE] = 1'b0;
        end
        // an idle instruction in the wake cycle wins: software asked last
        if (IDLE_EXEC) begin
            nxt_idle_status_reg = icr_ff; // R17
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            icr_ff <= idle_entry_pkg::ICR_RST;
            idle_status_reg_ff <= idle_entry_pkg::ICR_RST;
            peripheral_idle_ctrl_ff <= idle_entry_pkg::PERIPHERAL_IDLE_CTRL_RST;
            master_idle_ctrl_ff <= idle_entry_pkg::MASTER_IDLE_CTRL_RST;
            pdreq_ff <= idle_entry_pkg::PDREQ_RST;
        end else begin
            icr_ff <= nxt_icr;
            idle_status_reg_ff <= nxt_idle_status_reg;
            peripheral_idle_ctrl_ff <= nxt_peripheral_idle_ctrl;
            master_idle_ctrl_ff <= nxt_master_idle_ctrl;
            pdreq_ff <= nxt_pdreq;
        end
    end

    // register reads; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            idle_entry_pkg::ADDR_IDLE_CTRL: rd_data = {22'h000000, icr_ff};
            idle_entry_pkg::ADDR_IDLE_STATUS: rd_data = {22'h000000, idle_status_reg_ff};
            idle_entry_pkg::ADDR_PERIPH_CTRL: rd_data = {18'h00000, peripheral_idle_ctrl_ff};
            idle_entry_pkg::ADDR_MASTER_CTRL: rd_data = {30'h00000000, master_idle_ctrl_ff};
            idle_entry_pkg::ADDR_PWRDN_REQ: rd_data = {30'h00000000, pdreq_ff};
            idle_entry_pkg::ADDR_CLK_STATE:
                rd_data = {11'h000, osc_pd_ff, pll_pd_ff, aux_stop_ff, cpu_stop_ff, MOD_CLK_STOP};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // cpu domain and clock generator
    always_comb begin
        nxt_cpu_stop = idle_status_reg_ff[idle_entry_pkg::ICR_CPU] && PIPE_STOPPED; // R03
        nxt_aux_stop = idle_status_reg_ff[idle_entry_pkg::ICR_CPU] && cpu_stop_ff; // R04
        // powering down with the cpu still clocked is not a valid mix
        nxt_pll_pd = idle_status_reg_ff[idle_entry_pkg::ICR_CLKGEN] && pdreq_ff[idle_entry_pkg::PD_PLL]
            && cpu_stop_ff; // R15
        nxt_osc_pd = idle_status_reg_ff[idle_entry_pkg::ICR_CLKGEN] && pdreq_ff[idle_entry_pkg::PD_OSC]
            && cpu_stop_ff; // R15
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cpu_stop_ff <= 1'b0;
            aux_stop_ff <= 1'b0;
            pll_pd_ff <= 1'b0;
            osc_pd_ff <= 1'b0;
        end else begin
            cpu_stop_ff <= nxt_cpu_stop;
            aux_stop_ff <= nxt_aux_stop;
            pll_pd_ff <= nxt_pll_pd;
            osc_pd_ff <= nxt_osc_pd;
        end
    end

    assign CPU_CLK_STOP = cpu_stop_ff;
    assign CPU_AUX_CLK_STOP = aux_stop_ff;
    assign PLL_POWER_DOWN = pll_pd_ff;
    assign OSC_POWER_DOWN = osc_pd_ff;

    // per-module request, quiet condition and wake
    always_comb begin
        mod_req = '0;
        mod_quiet = '1;
        mod_wake = '0;
        for (int i = 0; i < idle_entry_pkg::NUM_PERIPH; i++) begin
            mod_req[i] = peripheral_idle_ctrl_ff[i] && idle_status_reg_ff[idle_entry_pkg::ICR_PERIPH]; // R01 R18
        end
        mod_req[idle_entry_pkg::MOD_EXTERNAL_MEMORY_INTERFACE] = mod_req[idle_entry_pkg::MOD_EXTERNAL_MEMORY_INTERFACE]
            || idle_status_reg_ff[idle_entry_pkg::ICR_EXTERNAL_MEMORY_INTERFACE];
        mod_req[idle_entry_pkg::MOD_DMA] = master_idle_ctrl_ff[idle_entry_pkg::MASTER_IDLE_CTRL_DMA]
            && idle_status_reg_ff[idle_entry_pkg::ICR_MASTER]; // R19
        mod_req[idle_entry_pkg::MOD_HOST] = master_idle_ctrl_ff[idle_entry_pkg::MASTER_IDLE_CTRL_HOST]
            && idle_status_reg_ff[idle_entry_pkg::ICR_MASTER]; // R19
        mod_req[idle_entry_pkg::MOD_INSTRUCTION_CACHE] = idle_status_reg_ff[idle_entry_pkg::ICR_INSTRUCTION_CACHE];
        for (int i = 0; i < idle_entry_pkg::NUM_MOD; i++) begin
            case (idle_entry_pkg::mod_kind(i))
                idle_entry_pkg::KIND_NOW: mod_quiet[i] = 1'b1; // R07 R09
                idle_entry_pkg::KIND_DRAIN: mod_quiet[i] = !MOD_BUSY[i]; // R05 R08 R13 R14
                idle_entry_pkg::KIND_EXTERNAL_MEMORY_INTERFACE: mod_quiet[i] = !MOD_BUSY[idle_entry_pkg::MOD_DMA]; // R16
                default: mod_quiet[i] = 1'b1;
            endcase
        end
        for (int j = 0; j < 2; j++) begin
            if (SSP_EXT_CLOCK[j]) begin
                mod_quiet[idle_entry_pkg::MOD_SSP0 + j] = !MOD_BUSY[idle_entry_pkg::MOD_SSP0 + j]; // R10
                mod_wake[idle_entry_pkg::MOD_SSP0 + j] = MOD_BUSY[idle_entry_pkg::MOD_SSP0 + j]; // R11
            end else begin
                // running its own clock it idles only while held in reset
                mod_quiet[idle_entry_pkg::MOD_SSP0 + j] = !TRANSMITTER_RESET_CTRL[j]
                    && !RECEIVER_RESET_CTRL[j]; // R12
            end
        end
        mod_wake[idle_entry_pkg::MOD_DMA] = mod_wake[idle_entry_pkg::MOD_SSP0]
            || mod_wake[idle_entry_pkg::MOD_SSP1]; // R06
    end

    genvar gi;
    generate
        for (gi = 0; gi < idle_entry_pkg::NUM_MOD; gi++) begin : g_slot
            idle_gate_slot u_slot (
                .clk(CLK_SYS),
                .rst_n(RESET_N),
                .req(mod_req[gi]),
                .ack(MOD_ACK[gi]),
                .quiet(mod_quiet[gi]),
                .wake(mod_wake[gi]),
                .stop(MOD_CLK_STOP[gi]),
                .hold(MOD_HOLD_START[gi])
            );
        end
    endgenerate

    assign MOD_IDLE_REQ = mod_req;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    cpu_pipe_stop_a: assert property (CPU_CLK_STOP |-> $past(PIPE_STOPPED)) // R03
        else $error("cpu clock stopped before pipeline stopped");
    aux_after_cpu_a: assert property ($rose(CPU_AUX_CLK_STOP) |-> $past(CPU_CLK_STOP)) // R04
        else $error("cpu-domain controllers gated before cpu stopped");
    pll_request_a: assert property (PLL_POWER_DOWN |-> $past(pdreq_ff[idle_entry_pkg::PD_PLL])) // R15
        else $error("pll powered down without request");
    status_copy_a: assert property (IDLE_EXEC |=> idle_status_reg_ff == $past(icr_ff)) // R17
        else $error("idle status not loaded from idle control");
    ssp_internal_a: assert property ($rose(MOD_CLK_STOP[idle_entry_pkg::MOD_SSP0]) |->
        $past(SSP_EXT_CLOCK[0]) || !$past(TRANSMITTER_RESET_CTRL[0] || RECEIVER_RESET_CTRL[0])) // R12
        else $error("internal-clock serial port idled out of reset");
    external_memory_interface_dma_a: assert property ($rose(MOD_CLK_STOP[idle_entry_pkg::MOD_EXTERNAL_MEMORY_INTERFACE]) |->
        !$past(MOD_BUSY[idle_entry_pkg::MOD_DMA])) // R16
        else $error("memory interface gated during dma transfer");
    dma_drain_a: assert property ($rose(MOD_CLK_STOP[idle_entry_pkg::MOD_DMA]) |->
        !$past(MOD_BUSY[idle_entry_pkg::MOD_DMA])) // R05
        else $error("dma gated mid transfer");
    host_now_a: assert property ((MOD_IDLE_REQ[idle_entry_pkg::MOD_HOST]
        && MOD_ACK[idle_entry_pkg::MOD_HOST]) [*2] |=> MOD_CLK_STOP[idle_entry_pkg::MOD_HOST]) // R07
        else $error("host port not idled at once");
    instruction_cache_drain_a: assert property ($rose(MOD_CLK_STOP[idle_entry_pkg::MOD_INSTRUCTION_CACHE]) |->
        !$past(MOD_BUSY[idle_entry_pkg::MOD_INSTRUCTION_CACHE])) // R08
        else $error("instruction cache gated mid access");
endmodule // module_idle_entry_control
`default_nettype wire

// file: verilog/idle_entry_pkg.sv
// idle-entry constants, register map, module indices and kinds
`default_nettype none
package idle_entry_pkg;
    localparam int NUM_MOD = 17;
    localparam int NUM_PERIPH = 14;
    localparam int ICR_W = 10;
    localparam int AW = 8;
    // register byte offsets
    localparam logic [7:0] ADDR_IDLE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IDLE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PERIPH_CTRL = 8'h08;
    localparam logic [7:0] ADDR_MASTER_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_PWRDN_REQ = 8'h10;
    localparam logic [7:0] ADDR_CLK_STATE = 8'h14;
    // reset values
    localparam logic [9:0] ICR_RST = 10'h000;
    localparam logic [13:0] PERIPHERAL_IDLE_CTRL_RST = 14'h0000;
    localparam logic [1:0] MASTER_IDLE_CTRL_RST = 2'h0;
    localparam logic [1:0] PDREQ_RST = 2'h0;
    // idle control / status bit positions
    localparam int ICR_CPU = 0;
    localparam int ICR_MASTER = 1;
    localparam int ICR_INSTRUCTION_CACHE = 2;
    localparam int ICR_PERIPH = 3;
    localparam int ICR_CLKGEN = 4;
    localparam int ICR_EXTERNAL_MEMORY_INTERFACE = 5;
    localparam int MASTER_IDLE_CTRL_DMA = 0;
    localparam int MASTER_IDLE_CTRL_HOST = 1;
    localparam int PD_PLL = 0;
    localparam int PD_OSC = 1;
    // module slots: 0..13 follow the peripheral control bits
    localparam int MOD_TIMER0 = 0;
    localparam int MOD_TIMER1 = 1;
    localparam int MOD_WATCHDOG = 2;
    localparam int MOD_OS_TIMER = 3;
    localparam int MOD_GPIO = 4;
    localparam int MOD_PAR_GPIO = 5;
    localparam int MOD_CLK_DIV = 6;
    localparam int MOD_SSP0 = 7;
    localparam int MOD_SSP1 = 8;
    localparam int MOD_I2C = 9;
    localparam int MOD_UART = 10;
    localparam int MOD_EXTERNAL_MEMORY_INTERFACE = 11;
    localparam int MOD_DMA = 14;
    localparam int MOD_HOST = 15;
    localparam int MOD_INSTRUCTION_CACHE = 16;

    typedef enum logic [1:0] {KIND_NOW, KIND_DRAIN, KIND_SSP, KIND_EXTERNAL_MEMORY_INTERFACE} kind_t;

    function automatic kind_t mod_kind(input int idx);
        case (idx)
            MOD_SSP0, MOD_SSP1: mod_kind = KIND_SSP;
            MOD_I2C, MOD_UART, MOD_DMA, MOD_INSTRUCTION_CACHE: mod_kind = KIND_DRAIN;
            MOD_EXTERNAL_MEMORY_INTERFACE: mod_kind = KIND_EXTERNAL_MEMORY_INTERFACE;
            default: mod_kind = KIND_NOW;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: verilog/idle_gate_slot.sv
// per-module idle entry sequencer: request, drain, gate, auto-wake
`default_nettype none
module idle_gate_slot (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // conditions
    input wire logic req,
    input wire logic ack,
    input wire logic quiet,
    input wire logic wake,
    // results
    output logic stop,
    output logic hold
);
    typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_IDLE, ST_AUTO} slot_state_t;
    slot_state_t state_ff, nxt_state;
    logic stop_ff, nxt_stop, hold_ff, nxt_hold;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (req) begin // R01
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!req) begin
                    nxt_state = ST_RUN;
                end else if (quiet && ack) begin // R02 R20
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!req) begin
                    nxt_state = ST_RUN;
                end else if (wake) begin // R06 R11
                    nxt_state = ST_AUTO;
                end
            end
            ST_AUTO: begin
                // back to sleep only once the woken transfer is done
                if (!req) begin
                    nxt_state = ST_RUN;
                end else if (quiet && ack && !wake) begin // R11
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
        nxt_stop = (nxt_state == ST_IDLE);
        nxt_hold = (nxt_state == ST_DRAIN); // R21
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
            stop_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            stop_ff <= nxt_stop;
            hold_ff <= nxt_hold;
        end
    end

    assign stop = stop_ff;
    assign hold = hold_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    gate_after_ack_a: assert property ($rose(stop_ff) |-> $past(ack) && $past(quiet) && $past(req)) // R20
        else $error("clock gated without acknowledge and quiet module");
    clear_ctrl_runs_a: assert property (!req |=> !stop_ff && !hold_ff) // R01
        else $error("module gated or held while its idle control is clear");
    hold_not_gated_a: assert property (hold_ff |-> !stop_ff ##1 (stop_ff || hold_ff || !$past(req))) // R21
        else $error("start hold released before gating");
endmodule // idle_gate_slot
`default_nettype wire

// file: verilog/ahb_reg_port.sv
// ahb-lite slave front end: writes zero-wait, reads one wait state
`default_nettype none
module ahb_reg_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // register side
    output logic wr_stb,
    output logic [7:0] reg_addr,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_data
);
    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RDWAIT, PH_RDDONE} phase_t;
    phase_t phase_ff, nxt_phase;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic take;

    always_comb begin
        take = hsel && htrans[1] && hready;
        nxt_addr = take ? haddr[7:0] : addr_ff;
        nxt_hrdata = hrdata_ff;
        if (phase_ff == PH_RDWAIT) begin
            // the wait cycle lets a preceding write land before sampling
            nxt_phase = PH_RDDONE;
            nxt_hrdata = rd_data;
        end else if (take) begin
            nxt_phase = hwrite ? PH_WRITE : PH_RDWAIT;
        end else begin
            nxt_phase = PH_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= PH_IDLE;
            addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            phase_ff <= nxt_phase;
            addr_ff <= nxt_addr;
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hreadyout = (phase_ff != PH_RDWAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign wr_stb = (phase_ff == PH_WRITE);
    assign reg_addr = addr_ff;
    assign wr_data = hwdata;
endmodule // ahb_reg_port
`default_nettype wire

// file: testbench/idle_partner.sv
// far-side model of the gated modules: activity and idle acknowledge
`default_nettype none
module idle_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // from the power manager
    input wire logic [16:0] idle_req,
    input wire logic [16:0] hold_start,
    // scenario control
    input wire logic [16:0] start,
    input wire logic [16:0] finish,
    // to the power manager
    output logic [16:0] busy,
    output logic [16:0] ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] busy_ff, ack_ff, nxt_busy, nxt_ack;
    always_comb begin
        // a draining module refuses new starts; the current one still runs to its end
        nxt_busy = (busy_ff | (start & ~hold_start)) & ~finish;
        // ack one cycle after the request, whatever the activity
        nxt_ack = idle_req;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 17'h0;
            ack_ff <= 17'h0;
        end else begin
            busy_ff <= nxt_busy;
            ack_ff <= nxt_ack;
        end
    end
    assign busy = busy_ff;
    assign ack = ack_ff;
endmodule // idle_partner
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the idle-entry power manager
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, cpu_stop, aux_stop, pll_pd, osc_pd;
    logic idle_exec = 1'b0, pipe_stopped = 1'b0, cpu_wake = 1'b0;
    logic [16:0] busy, ack, req, hold, stop;
    logic [16:0] start = 17'h0, finish = 17'h0;
    logic [1:0] ext_clk = 2'h0, tx_rst = 2'h0, rx_rst = 2'h0;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    module_idle_entry_control i_module_idle_entry_control (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .IDLE_EXEC(idle_exec), .PIPE_STOPPED(pipe_stopped), .CPU_WAKE(cpu_wake),
        .CPU_CLK_STOP(cpu_stop), .CPU_AUX_CLK_STOP(aux_stop), .PLL_POWER_DOWN(pll_pd),
        .OSC_POWER_DOWN(osc_pd), .MOD_BUSY(busy), .MOD_ACK(ack), .MOD_IDLE_REQ(req),
        .MOD_HOLD_START(hold), .MOD_CLK_STOP(stop), .SSP_EXT_CLOCK(ext_clk),
        .TRANSMITTER_RESET_CTRL(tx_rst), .RECEIVER_RESET_CTRL(rx_rst));
    idle_partner i_idle_partner (.clk(clk_sys), .rst_n(reset_n), .idle_req(req), .hold_start(hold),
        .start(start), .finish(finish), .busy(busy), .ack(ack));

    always #10 clk_sys = ~clk_sys;

    task automatic final_report();
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the whole run needs a few hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // ready and read data are sampled at the negedge, settled before the edge that takes them
    task automatic wait_ready();
        logic r;
        do begin
            @(negedge clk_sys);
            r = hreadyout;
            rd = hrdata;
            @(posedge clk_sys);
        end while (r !== 1'b1);
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic pulse_exec();
        @(posedge clk_sys);
        idle_exec <= 1'b1;
        @(posedge clk_sys);
        idle_exec <= 1'b0;
    endtask

    task automatic kick(input logic [16:0] s, input logic [16:0] f);
        @(posedge clk_sys);
        start <= s;
        finish <= f;
        @(posedge clk_sys);
        start <= 17'h0;
        finish <= 17'h0;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        tx_rst <= 2'h0;
        rx_rst <= 2'h0;
        ext_clk <= 2'h0;
        pipe_stopped <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask

    task automatic t_regs();
        logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
        logic [31:0] m [6] = '{32'h3ff, 32'h0, 32'h3fff, 32'h3, 32'h3, 32'h0};
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, a[i], 32'h0);
            `CHK("reset value", 32'h0, rd)
            ahb(1'b1, a[i], 32'hffff_ffff);
            ahb(1'b0, a[i], 32'h0);
            `CHK("readback", m[i], rd)
        end
        ahb(1'b1, 8'h18, 32'hffff_ffff);
        ahb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hresp", 1'b0, hresp)
        do_reset();
    endtask

    task automatic t_immediate();
        ahb(1'b1, idle_entry_pkg::ADDR_PERIPH_CTRL, 32'h6f);
        ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'h8);
        step(4);
        `CHK("no gate before idle", 17'h0, stop)
        pulse_exec();
        step(6);
        `CHK("gated set", 17'h6f, stop)
        `CHK("idle request", 17'h6f, req)
        ahb(1'b0, idle_entry_pkg::ADDR_IDLE_STATUS, 32'h0);
        `CHK("status copy", 32'h8, rd)
        ahb(1'b0, idle_entry_pkg::ADDR_CLK_STATE, 32'h0);
        `CHK("clock state", 32'h6f, rd)
        do_reset();
    endtask

    task automatic t_drain();
        kick(17'h600, 17'h0);
        ahb(1'b1, idle_entry_pkg::ADDR_PERIPH_CTRL, 32'h600);
        ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'h8);
        pulse_exec();
        step(5);
        `CHK("both busy", 17'h0, stop)
        `CHK("hold start", 17'h600, hold)
        kick(17'h0, 17'h200);
        step(5);
        `CHK("two-wire done", 17'h200, stop)
        kick(17'h0, 17'h400);
        step(5);
        `CHK("uart done", 17'h600, stop)
        do_reset();
    endtask

    task automatic t_cpu();
        ahb(1'b1, idle_entry_pkg::ADDR_PWRDN_REQ, 32'h1);
        ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'h11);
        pulse_exec();
        step(4);
        `CHK("pipe running", 4'h0, {cpu_stop, aux_stop, pll_pd, osc_pd})
        @(posedge clk_sys);
        pipe_stopped <= 1'b1;
        step(5);
        `CHK("cpu idle", 4'he, {cpu_stop, aux_stop, pll_pd, osc_pd})
        ahb(1'b0, idle_entry_pkg::ADDR_CLK_STATE, 32'h0);
        `CHK("clock state", 32'he0000, rd)
        @(posedge clk_sys);
        cpu_wake <= 1'b1;
        @(posedge clk_sys);
        cpu_wake <= 1'b0;
        step(4);
        `CHK("cpu woken", 1'b0, cpu_stop)
        do_reset();
    endtask

    // port0 blocked by each reset control in turn (transmit, then receive), then both free to idle
    task automatic t_ssp_int();
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            tx_rst <= (k == 0) ? 2'b01 : 2'b00;
            rx_rst <= (k == 1) ? 2'b01 : 2'b00;
            ahb(1'b1, idle_entry_pkg::ADDR_PERIPH_CTRL, 32'h180);
            ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'h8);
            pulse_exec();
            step(6);
            `CHK("internal clock port", ((k == 2) ? 17'h180 : 17'h100), stop)
            do_reset();
        end
    endtask

    task automatic t_master();
        kick(17'h1c000, 17'h0);
        ahb(1'b1, idle_entry_pkg::ADDR_MASTER_CTRL, 32'h3);
        ahb(1'b1, idle_entry_pkg::ADDR_PERIPH_CTRL, 32'h800);
        ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'he);
        pulse_exec();
        step(5);
        `CHK("host only", 17'h8000, stop)
        kick(17'h0, 17'h10000);
        step(5);
        `CHK("cache done", 17'h18000, stop)
        kick(17'h0, 17'h4000);
        step(5);
        `CHK("dma done", 17'h1c800, stop)
        ahb(1'b1, idle_entry_pkg::ADDR_MASTER_CTRL, 32'h1);
        step(4);
        `CHK("host control clear", 17'h14800, stop)
        do_reset();
    endtask

    task automatic t_autowake();
        @(posedge clk_sys);
        ext_clk <= 2'b01;
        ahb(1'b1, idle_entry_pkg::ADDR_MASTER_CTRL, 32'h1);
        ahb(1'b1, idle_entry_pkg::ADDR_PERIPH_CTRL, 32'h80);
        ahb(1'b1, idle_entry_pkg::ADDR_IDLE_CTRL, 32'ha);
        pulse_exec();
        step(6);
        `CHK("port and dma idle", 17'h4080, stop)
        kick(17'h80, 17'h0);
        step(2);
        `CHK("auto wake", 17'h0, stop)
        kick(17'h0, 17'h80);
        step(5);
        `CHK("back to idle", 17'h4080, stop)
        do_reset();
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        t_immediate();
        t_drain();
        t_cpu();
        t_ssp_int();
        t_master();
        t_autowake();
        final_report();
    end
endmodule // tb
`default_nettype wire
